/* File: logic/pcms_pkg.sv */
// Package: constants and carrier types of the message and credit sideband
package pcms_pkg;
  // AXI4-Lite geometry and register byte offsets
  localparam int AXI_ADDR_W = 6;
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 6'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 6'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_RX_COUNT = 6'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_TX_COUNT = 6'h0c;
  // CTRL fields and reset value
  localparam int CTRL_RX_EN_BIT = 0;
  localparam int CTRL_TX_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  // STATUS fields
  localparam int STATUS_RX_BUSY_BIT = 0;
  localparam int STATUS_TX_BUSY_BIT = 1;
  localparam int STATUS_REJ_LSB = 8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Received message kind codes
  localparam logic [4:0] RX_ERR_COR = 5'h00;
  localparam logic [4:0] RX_SLOT_POWER = 5'h0f;
  localparam logic [4:0] RX_LTR = 5'h10;
  localparam logic [4:0] RX_RESERVED17 = 5'h11;
  localparam logic [4:0] RX_UNLOCK = 5'h12;
  localparam logic [4:0] RX_VENDOR0 = 5'h13;
  localparam logic [4:0] RX_VENDOR1 = 5'h14;
  // Delivery lengths in cycles
  localparam logic [3:0] RX_LEN_SHORT = 4'h2;
  localparam logic [3:0] RX_LEN_LONG = 4'h6;
  localparam logic [3:0] RX_LEN_VDM = 4'h4;
  localparam logic [3:0] RX_LEN_VDM_DATA = 4'h8;
  // Transmit kind codes
  localparam logic [2:0] TX_LTR = 3'h0;
  localparam logic [2:0] TX_OBFF = 3'h1;
  localparam logic [2:0] TX_SLOT_POWER = 3'h2;
  localparam logic [2:0] TX_PME = 3'h3;
  // Credit view selects
  localparam logic [2:0] SEL_RX_AVAIL = 3'h0;
  localparam logic [2:0] SEL_RX_CONSUMED = 3'h2;
  localparam logic [2:0] SEL_TX_AVAIL = 3'h4;
  localparam logic [2:0] SEL_TX_LIMIT = 3'h5;
  localparam logic [2:0] SEL_TX_CONSUMED = 3'h6;
  localparam int NUM_VIEWS = 5;
  // Infinite-credit encodings
  localparam logic [7:0] INF_HDR_TX = 8'h80;
  localparam logic [11:0] INF_DAT_TX = 12'h800;
  localparam logic [7:0] INF_HDR_OTHER = 8'h00;
  localparam logic [11:0] INF_DAT_OTHER = 12'h000;

  // Decoded message handed over by the link layer
  typedef struct packed {
    logic [4:0] kind;
    logic [7:0] bus;
    logic [7:0] devfn;
    logic [15:0] vendor;
    logic [31:0] payload;
    logic has_data;
  } pcms_rx_msg_t;

  // One credit view; inf bits ordered ph, pd, nph, npd, cplh, cpld from bit 0
  typedef struct packed {
    logic [5:0] inf;
    logic [7:0] ph;
    logic [11:0] pd;
    logic [7:0] nph;
    logic [11:0] npd;
    logic [7:0] cplh;
    logic [11:0] cpld;
  } pcms_credit_t;

  typedef struct packed {
    logic [2:0] kind;
    logic [31:0] data;
  } pcms_tx_req_t;
endpackage

/* File: logic/pcms_sideband.sv */
// Module: received-message delivery, message transmit handshake, credit view mux
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module pcms_sideband
  import pcms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoded messages from the link layer
  input wire pcms_rx_msg_t link_rx_msg,
  input wire logic link_rx_valid,
  output logic link_rx_ready,
  // Received message interface to user logic
  output logic msg_received,
  output logic [7:0] msg_received_data,
  output logic [4:0] msg_received_type,
  // Transmit message interface from user logic
  input wire logic msg_transmit,
  input wire pcms_tx_req_t msg_transmit_req,
  output logic msg_transmit_done,
  // Encoded message towards the link layer
  output pcms_tx_req_t link_tx_req,
  output logic link_tx_valid,
  input wire logic link_tx_ready,
  // Credit views from the flow-control logic and the multiplexed outputs
  input wire pcms_credit_t credit_views [NUM_VIEWS],
  input wire logic [2:0] credit_view_select,
  output logic [7:0] credit_posted_header,
  output logic [11:0] credit_posted_payload,
  output logic [7:0] credit_nonposted_header,
  output logic [11:0] credit_nonposted_payload,
  output logic [7:0] credit_completion_header,
  output logic [11:0] credit_completion_payload
);

  typedef enum logic [2:0] {
    PCMS_RX_IDLE = 3'b001,
    PCMS_RX_SEND = 3'b010,
    PCMS_RX_GAP = 3'b100
  } pcms_rx_state_t;

  typedef enum logic [2:0] {
    PCMS_TX_IDLE = 3'b001,
    PCMS_TX_WAIT = 3'b010,
    PCMS_TX_DONE = 3'b100
  } pcms_tx_state_t;

  pcms_rx_state_t rx_state_q;
  pcms_tx_state_t tx_state_q;
  logic [1:0] ctrl_q;
  logic [31:0] rx_count_q;
  logic [31:0] tx_count_q;
  logic [7:0] rej_count_q;
  logic [55:0] rx_shift_q;
  logic [2:0] rx_left_q;
  pcms_rx_msg_t rx_msg_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [2:0] sel_q;

  // Kind decode: length in cycles, zero for reserved codes
  function automatic logic [3:0] rx_len(input pcms_rx_msg_t m);
    if (m.kind < RX_SLOT_POWER || m.kind == RX_UNLOCK) begin
      rx_len = RX_LEN_SHORT;
    end else if (m.kind == RX_SLOT_POWER || m.kind == RX_LTR) begin
      rx_len = RX_LEN_LONG;
    end else if (m.kind == RX_VENDOR0 || m.kind == RX_VENDOR1) begin
      rx_len = m.has_data ? RX_LEN_VDM_DATA : RX_LEN_VDM;
    end else begin
      rx_len = 4'h0;
    end
  endfunction

  // Byte sequence after the bus number, low byte first
  function automatic logic [55:0] rx_bytes(input pcms_rx_msg_t m);
    if (m.kind == RX_VENDOR0 || m.kind == RX_VENDOR1) begin
      rx_bytes = {m.payload, m.vendor, m.devfn};
    end else begin
      rx_bytes = {16'h0000, m.payload, m.devfn};
    end
  endfunction

  logic rx_take;
  logic [3:0] take_len;
  assign rx_take = link_rx_valid && link_rx_ready;
  assign take_len = rx_len(link_rx_msg);

  // Receive delivery; ready is withheld during send and the gap, stalling the link layer
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state_q <= PCMS_RX_IDLE;
      link_rx_ready <= 1'b0;
      msg_received <= 1'b0;
      msg_received_data <= 8'h00;
      msg_received_type <= 5'h00;
      rx_shift_q <= 56'h0;
      rx_left_q <= 3'h0;
      rx_msg_q <= '0;
    end else begin
      case (rx_state_q)
        PCMS_RX_IDLE: begin
          link_rx_ready <= ctrl_q[CTRL_RX_EN_BIT];
          if (rx_take && take_len != 4'h0) begin
            rx_state_q <= PCMS_RX_SEND;
            link_rx_ready <= 1'b0;
            msg_received <= 1'b1;
            msg_received_data <= link_rx_msg.bus;
            msg_received_type <= link_rx_msg.kind;
            rx_shift_q <= rx_bytes(link_rx_msg);
            rx_left_q <= 3'(take_len - 4'h1);
            rx_msg_q <= link_rx_msg;
          end
        end
        PCMS_RX_SEND: begin
          if (rx_left_q == 3'h1) begin
            rx_state_q <= PCMS_RX_SEND;
          end
          if (rx_left_q == 3'h0) begin
            msg_received <= 1'b0;
            msg_received_data <= 8'h00;
            rx_state_q <= PCMS_RX_GAP;
          end else begin
            msg_received_data <= rx_shift_q[7:0];
            rx_shift_q <= {8'h00, rx_shift_q[55:8]};
            rx_left_q <= rx_left_q - 3'h1;
          end
        end
        PCMS_RX_GAP: begin
          rx_state_q <= PCMS_RX_IDLE;
          link_rx_ready <= ctrl_q[CTRL_RX_EN_BIT];
        end
        default: begin
          rx_state_q <= PCMS_RX_IDLE;
          msg_received <= 1'b0;
          link_rx_ready <= 1'b0;
        end
      endcase
    end
  end

  // Transmit handshake; reserved kinds finish at once without touching the link
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state_q <= PCMS_TX_IDLE;
      link_tx_valid <= 1'b0;
      link_tx_req <= '0;
      msg_transmit_done <= 1'b0;
    end else begin
      case (tx_state_q)
        PCMS_TX_IDLE: begin
          if (msg_transmit && ctrl_q[CTRL_TX_EN_BIT]) begin
            if (msg_transmit_req.kind > TX_PME) begin
              msg_transmit_done <= 1'b1;
              tx_state_q <= PCMS_TX_DONE;
            end else begin
              link_tx_req <= msg_transmit_req;
              link_tx_valid <= 1'b1;
              tx_state_q <= PCMS_TX_WAIT;
            end
          end
        end
        PCMS_TX_WAIT: begin
          if (link_tx_ready) begin
            link_tx_valid <= 1'b0;
            msg_transmit_done <= 1'b1;
            tx_state_q <= PCMS_TX_DONE;
          end
        end
        PCMS_TX_DONE: begin
          msg_transmit_done <= 1'b0;
          tx_state_q <= PCMS_TX_IDLE;
        end
        default: begin
          tx_state_q <= PCMS_TX_IDLE;
          link_tx_valid <= 1'b0;
          msg_transmit_done <= 1'b0;
        end
      endcase
    end
  end

  // Activity counters
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_count_q <= 32'h0;
      tx_count_q <= 32'h0;
      rej_count_q <= 8'h00;
    end else begin
      if (rx_take && take_len != 4'h0) begin
        rx_count_q <= rx_count_q + 32'h1;
      end
      if (link_tx_valid && link_tx_ready) begin
        tx_count_q <= tx_count_q + 32'h1;
      end
      if (tx_state_q == PCMS_TX_IDLE && msg_transmit && ctrl_q[CTRL_TX_EN_BIT]
          && msg_transmit_req.kind > TX_PME) begin
        rej_count_q <= rej_count_q + 8'h01;
      end
    end
  end

  // Credit mux: select registered first so a changing select never glitches outputs
  function automatic logic [11:0] credit_pick(input logic inf, input logic [11:0] val,
                                              input logic [11:0] inf_code);
    credit_pick = inf ? inf_code : val;
  endfunction

  // Header fields get their own picker so no select is taken on a call result
  function automatic logic [7:0] hdr_pick(input logic inf, input logic [7:0] val,
                                          input logic [7:0] inf_code);
    hdr_pick = inf ? inf_code : val;
  endfunction

  pcms_credit_t view;
  logic sel_valid;
  logic tx_avail;
  always_comb begin
    view = '0;
    sel_valid = 1'b1;
    case (sel_q)
      SEL_RX_AVAIL: view = credit_views[0];
      SEL_RX_CONSUMED: view = credit_views[1];
      SEL_TX_AVAIL: view = credit_views[2];
      SEL_TX_LIMIT: view = credit_views[3];
      SEL_TX_CONSUMED: view = credit_views[4];
      default: sel_valid = 1'b0;
    endcase
  end
  assign tx_avail = (sel_q == SEL_TX_AVAIL);

  logic [7:0] hdr_inf;
  logic [11:0] dat_inf;
  assign hdr_inf = tx_avail ? INF_HDR_TX : INF_HDR_OTHER;
  assign dat_inf = tx_avail ? INF_DAT_TX : INF_DAT_OTHER;

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_q <= SEL_RX_AVAIL;
      credit_posted_header <= 8'h00;
      credit_posted_payload <= 12'h000;
      credit_nonposted_header <= 8'h00;
      credit_nonposted_payload <= 12'h000;
      credit_completion_header <= 8'h00;
      credit_completion_payload <= 12'h000;
    end else begin
      sel_q <= credit_view_select;
      if (sel_valid) begin
        credit_posted_header <= hdr_pick(view.inf[0], view.ph, hdr_inf);
        credit_posted_payload <= credit_pick(view.inf[1], view.pd, dat_inf);
        credit_nonposted_header <= hdr_pick(view.inf[2], view.nph, hdr_inf);
        credit_nonposted_payload <= credit_pick(view.inf[3], view.npd, dat_inf);
        credit_completion_header <= hdr_pick(view.inf[4], view.cplh, hdr_inf);
        credit_completion_payload <= credit_pick(view.inf[5], view.cpld, dat_inf);
      end else begin
        credit_posted_header <= 8'h00;
        credit_posted_payload <= 12'h000;
        credit_nonposted_header <= 8'h00;
        credit_nonposted_payload <= 12'h000;
        credit_completion_header <= 8'h00;
        credit_completion_payload <= 12'h000;
      end
    end
  end

  // AXI4-Lite write: address and data taken in either order, response two cycles after the later one
  logic do_write;
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      ctrl_q <= CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        if (awaddr_q == REG_CTRL) begin
          if (wstrb_q[0]) begin
            ctrl_q <= wdata_q[1:0];
          end
        end else if (awaddr_q != REG_STATUS && awaddr_q != REG_RX_COUNT
                     && awaddr_q != REG_TX_COUNT) begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read: data one cycle after the address is taken
  logic [31:0] status_word;
  assign status_word = {16'h0000, rej_count_q, 6'h00,
                        tx_state_q != PCMS_TX_IDLE, rx_state_q != PCMS_RX_IDLE};
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          REG_CTRL: s_axi_rdata <= {30'h0, ctrl_q};
          REG_STATUS: s_axi_rdata <= status_word;
          REG_RX_COUNT: s_axi_rdata <= rx_count_q;
          REG_TX_COUNT: s_axi_rdata <= tx_count_q;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Checks
  logic take_short;
  logic take_long;
  logic take_vdm;
  assign take_short = rx_take && take_len == RX_LEN_SHORT;
  assign take_long = rx_take && take_len == RX_LEN_LONG;
  assign take_vdm = rx_take && (link_rx_msg.kind == RX_VENDOR0 || link_rx_msg.kind == RX_VENDOR1);

  sequence s_flag_two;
    msg_received [*2] ##1 !msg_received;
  endsequence
  sequence s_flag_six;
    msg_received [*6] ##1 !msg_received;
  endsequence
  sequence s_vendor_bytes;
    ##1 msg_received_data == rx_msg_q.devfn ##1 msg_received_data == rx_msg_q.vendor[7:0]
      ##1 msg_received_data == rx_msg_q.vendor[15:8];
  endsequence

  a_rx_short_len: assert property (@(posedge clk) disable iff (reset)
    take_short |=> s_flag_two) else $error("short message flag length wrong");
  a_rx_long_len: assert property (@(posedge clk) disable iff (reset)
    take_long |=> s_flag_six) else $error("six-cycle message flag length wrong");
  a_rx_ltr_bytes: assert property (@(posedge clk) disable iff (reset)
    rx_take && link_rx_msg.kind == RX_LTR |=> ##3 msg_received_data == rx_msg_q.payload[15:8])
    else $error("snoop latency high byte misplaced");
  a_rx_vdm_len: assert property (@(posedge clk) disable iff (reset)
    take_vdm |=> msg_received [*4] ##1 (msg_received == rx_msg_q.has_data))
    else $error("vendor message flag length wrong");
  a_rx_vdm_vendor: assert property (@(posedge clk) disable iff (reset)
    take_vdm |=> s_vendor_bytes) else $error("vendor id bytes misplaced");
  a_rx_kind_code: assert property (@(posedge clk) disable iff (reset)
    msg_received |-> msg_received_type != RX_RESERVED17 && msg_received_type <= RX_VENDOR1)
    else $error("reserved message kind delivered");
  a_rx_gap_idle: assert property (@(posedge clk) disable iff (reset)
    $fell(msg_received) |=> !msg_received) else $error("no idle gap between messages");
  a_tx_done_pulse: assert property (@(posedge clk) disable iff (reset)
    link_tx_valid && link_tx_ready |=> msg_transmit_done ##1 !msg_transmit_done)
    else $error("done is not a single pulse after completion");
  a_credit_tx_inf: assert property (@(posedge clk) disable iff (reset)
    sel_q == SEL_TX_AVAIL && credit_views[2].inf[1] |=> credit_posted_payload == INF_DAT_TX)
    else $error("transmit infinite credit code wrong");
  a_credit_other_inf: assert property (@(posedge clk) disable iff (reset)
    sel_q == SEL_TX_LIMIT && credit_views[3].inf[0] |=> credit_posted_header == INF_HDR_OTHER)
    else $error("infinite credit not zero");
  a_credit_view_sel: assert property (@(posedge clk) disable iff (reset)
    credit_view_select == SEL_TX_CONSUMED ##1 !credit_views[4].inf[5]
      |=> credit_completion_payload == $past(credit_views[4].cpld))
    else $error("consumed credit view not shown");
endmodule

/* File: verification/pcms_link_model.sv */
// Link-side partner: takes encoded transmit requests after a chosen wait
`timescale 1ns/1ns
module pcms_link_model
  import pcms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Transmit link
  input wire pcms_tx_req_t link_tx_req,
  input wire logic link_tx_valid,
  output logic link_tx_ready,
  // Pacing and observation
  input wire logic [1:0] lat,
  output pcms_tx_req_t last_req,
  output int xfers
);
  logic [1:0] wait_q;

  // Ready only after lat cycles of valid, so both prompt and slow answers occur
  assign link_tx_ready = link_tx_valid && (wait_q == lat);

  always_ff @(posedge clk) begin
    if (reset || !link_tx_valid || link_tx_ready) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      xfers <= 0;
    end else if (link_tx_ready) begin
      xfers <= xfers + 1;
      last_req <= link_tx_req;
    end
  end
endmodule

/* File: verification/pcms_sideband_tb.sv */
// Self-checking bench of the message and credit sideband
`timescale 1ns/1ns
module pcms_sideband_tb
  import pcms_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, rx_valid = 0, tx = 0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic awready, wready, bvalid, arready, rvalid, rx_ready, rcv, done, tx_valid, tx_ready;
  logic [1:0] bresp, rresp;
  logic [1:0] lat = 2'h0;
  logic [7:0] rcv_data, ph, nph, cplh;
  logic [11:0] pd, npd, cpld;
  logic [4:0] rcv_type;
  logic [2:0] sel = 3'h0;
  pcms_rx_msg_t rx_msg = '0;
  pcms_tx_req_t tx_req = '0, link_req, last_req;
  pcms_credit_t views [NUM_VIEWS];
  int xfers, run = 0, nrx = 0, ntx = 0, nrej = 0, num_errors = 0, checks = 0;
  logic [31:0] seed = 32'd43980;
  logic [12:0] exp_q [$];
  int len_q [$];
  // Data bits each transmit kind may carry; reserved kinds pass anything
  localparam logic [31:0] DMASK [8] = '{0: 32'h9fff9fff, 1: 32'hf, 2: 32'h3ff, 3: 32'h3f3,
    default: 32'hffffffff};

  always #50 clk = ~clk;

  pcms_sideband u_pcms_sideband (.clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_rx_msg(rx_msg), .link_rx_valid(rx_valid), .link_rx_ready(rx_ready),
    .msg_received(rcv), .msg_received_data(rcv_data), .msg_received_type(rcv_type),
    .msg_transmit(tx), .msg_transmit_req(tx_req), .msg_transmit_done(done),
    .link_tx_req(link_req), .link_tx_valid(tx_valid), .link_tx_ready(tx_ready),
    .credit_views(views), .credit_view_select(sel),
    .credit_posted_header(ph), .credit_posted_payload(pd),
    .credit_nonposted_header(nph), .credit_nonposted_payload(npd),
    .credit_completion_header(cplh), .credit_completion_payload(cpld));

  pcms_link_model u_pcms_link_model (.clk(clk), .reset(reset), .link_tx_req(link_req),
    .link_tx_valid(tx_valid), .link_tx_ready(tx_ready), .lat(lat), .last_req(last_req),
    .xfers(xfers));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] a);
    checks++;
    if (a !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, a);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic axi_rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
  endtask

  // Queues the bytes a message must show, then offers it to the link input
  task automatic send_rx(input logic [4:0] k, input logic hd);
    pcms_rx_msg_t m;
    m = {k, rnd(), rnd(), hd};
    if (k != 5'h11 && k <= 5'h14) begin
      exp_q.push_back({k, m.bus});
      exp_q.push_back({k, m.devfn});
      if (k >= 5'h13) begin
        exp_q.push_back({k, m.vendor[7:0]});
        exp_q.push_back({k, m.vendor[15:8]});
      end
      if (k == 5'h0f || k == 5'h10 || (k >= 5'h13 && hd)) begin
        for (int i = 0; i < 4; i++) exp_q.push_back({k, m.payload[8*i +: 8]});
      end
      len_q.push_back(k == 5'h0f || k == 5'h10 ? 6 : k >= 5'h13 ? (hd ? 8 : 4) : 2);
      nrx++;
    end
    @(posedge clk);
    rx_msg <= m;
    rx_valid <= 1'b1;
    do @(posedge clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (reset) begin
      run = 0;
    end else if (rcv === 1'b1) begin
      run++;
      chk("rx byte", exp_q.size() ? exp_q.pop_front() : 13'h1fff,
          {rcv_type, rcv_data});
    end else if (run != 0) begin
      chk("rx length", len_q.pop_front(), run);
      run = 0;
    end
  end

  task automatic send_tx(input logic [2:0] k);
    pcms_tx_req_t r;
    int n;
    r = {k, rnd() & DMASK[k]};
    n = xfers;
    ntx += (k < 3'h4);
    nrej += (k >= 3'h4);
    @(posedge clk);
    lat <= 2'(rnd());
    tx_req <= r;
    tx <= 1'b1;
    do @(posedge clk); while (done !== 1'b1);
    tx <= 1'b0;
    @(posedge clk);
    chk("done width", 1'b0, done);
    chk("transfers", n + (k < 3'h4), xfers);
    if (k < 3'h4) chk("link request", r, last_req);
  endtask

  task automatic chk_credit(input logic [2:0] s);
    logic [59:0] e;
    logic [7:0] h;
    logic [11:0] d;
    pcms_credit_t v;
    @(posedge clk);
    for (int i = 0; i < NUM_VIEWS; i++) views[i] <= {rnd(), rnd(), 2'(rnd())};
    sel <= s;
    repeat (3) @(posedge clk);
    v = s == 3'h0 ? views[0] : s == 3'h2 ? views[1] : (s >= 3'h4 && s <= 3'h6) ? views[s - 2] : '0;
    h = s == 3'h4 ? 8'h80 : 8'h00;
    d = s == 3'h4 ? 12'h800 : 12'h000;
    e = v[59:0];
    if (v.inf[0]) e[59:52] = h;
    if (v.inf[1]) e[51:40] = d;
    if (v.inf[2]) e[39:32] = h;
    if (v.inf[3]) e[31:20] = d;
    if (v.inf[4]) e[19:12] = h;
    if (v.inf[5]) e[11:0] = d;
    chk("credits", e, {ph, pd, nph, npd, cplh, cpld});
  endtask

  initial begin
    for (int i = 0; i < NUM_VIEWS; i++) views[i] = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    axi_rd(REG_CTRL, 32'h3, RESP_OKAY);
    axi_rd(6'h10, 32'h0, RESP_SLVERR);
    axi_wr(6'h14, 32'h1, RESP_SLVERR);
    // Kinds 0 to 20 with reserved 17, vendor kinds again with data, reserved 25, then random traffic
    for (int i = 0; i < 24; i++) send_rx(i < 21 ? 5'(i) : i < 23 ? 5'(i - 2) : 5'h19, i > 20);
    for (int i = 0; i < 20; i++) send_rx(5'(rnd()), 1'(rnd()));
    axi_wr(REG_CTRL, 32'h2, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h2, RESP_OKAY);
    repeat (20) @(posedge clk);
    chk("rx ready off", 1'b0, rx_ready);
    for (int i = 0; i < 16; i++) send_tx(3'(i));
    axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
    repeat (20) @(posedge clk);
    chk("rx left", 0, exp_q.size());
    axi_rd(REG_RX_COUNT, nrx, RESP_OKAY);
    axi_rd(REG_TX_COUNT, ntx, RESP_OKAY);
    axi_rd(REG_STATUS, {16'h0, 8'(nrej), 8'h0}, RESP_OKAY);
    for (int s = 0; s < 8; s++) chk_credit(3'(s));
    repeat (8) chk_credit(3'(rnd()));
    final_report();
  end

  // Cuts a hang short well beyond the expected run of under a thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule
